/* File: pkg/wdtwk_pkg.sv */
// Purpose: Constants and types shared by the watchdog timer with wakeup.
// Assumes: AHB-Lite register access, 32-bit words, 200 MHz bus clock.
// Notes: The watchdog clock arrives as a pin-level tick and is synchronised.
package wdtwk_pkg;
  localparam logic [11:0] WDTWK_OFS_CTL = 12'h000;
  localparam logic [11:0] WDTWK_OFS_ALTCTL = 12'h004;
  localparam logic [11:0] WDTWK_OFS_STAT = 12'h008;
  localparam logic [11:0] WDTWK_OFS_MASK = 12'h00C;
  localparam logic [31:0] WDTWK_CTL_RST = 32'h0000_0700;
  localparam logic [31:0] WDTWK_ALT_RST = 32'h0000_0000;
  localparam int WDTWK_BIT_CLR = 0;
  localparam int WDTWK_BIT_RESET_ENABLE_BIT = 1;
  localparam int WDTWK_BIT_RSTF = 2;
  localparam int WDTWK_BIT_TOF = 3;
  localparam int WDTWK_BIT_WAKEUP_ENABLE_BIT = 4;
  localparam int WDTWK_BIT_WKF = 5;
  localparam int WDTWK_BIT_INTERRUPT_ENABLE_BIT = 6;
  localparam int WDTWK_BIT_EN = 7;
  localparam int WDTWK_TSEL_LSB = 8;
  localparam int WDTWK_CSEL_LSB = 12;
  localparam int WDTWK_CNT_W = 18;
  localparam int WDTWK_HOLD_CLKS = 63;
  localparam logic [1:0] WDTWK_CSEL_LXT = 2'b11;
  localparam logic [10:0] WDTWK_DLY_0 = 11'd1026;
  localparam logic [10:0] WDTWK_DLY_1 = 11'd130;
  localparam logic [10:0] WDTWK_DLY_2 = 11'd18;
  localparam logic [10:0] WDTWK_DLY_3 = 11'd3;
  localparam int WDTWK_EVT_TO = 0;
  localparam int WDTWK_EVT_RST = 1;
  localparam int WDTWK_EVT_WK = 2;

  typedef enum logic [1:0] {WDTWK_RUN, WDTWK_DELAY, WDTWK_HOLD} wdtwk_phase_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } wdtwk_aphase_t;

  typedef struct packed {
    logic wdt_tick;
    logic pd_enter;
    logic powered_down;
    logic force_on;
  } wdtwk_sys_in_t;

  typedef struct packed {
    logic cpu_rst;
    logic irq;
    logic wakeup;
    logic wk_src;
    logic rst_src;
  } wdtwk_sys_out_t;
endpackage

/* File: verilog/wdtwk_top.sv */
// Purpose: Watchdog timer with selectable timeout, reset delay, reset hold and wakeup.
// Assumes: wdt_tick is a level that toggles once per watchdog clock period from the selected source.
// Notes: Software selects the source in the alternate control register; the clock mux lives outside.
//
// The AHB-Lite slave port was decided locally.

// Operation
// (RULE_01) Eighteen-bit up counter on watchdog clock.
// (RULE_02) Three-bit select: two to four plus twice code.
// (RULE_03) Enable bit starts counter from zero.
// (RULE_04) Timeout flag set when count reaches select.
// (RULE_05) Interrupt enable raises interrupt on timeout.
// (RULE_06) Software clears counter within reset delay.
// (RULE_07) Reset delay: 1026, 130, 18 or 3.
// (RULE_08) Expired delay with reset enable resets CPU.
// (RULE_09) Reset held for 63 watchdog clocks.
// (RULE_10) Reset source flag survives watchdog reset.
// (RULE_11) Counter clears just before power-down entry.
// (RULE_12) Wakeup only on slow crystal with enable.
// (RULE_13) Wakeup sets wakeup source status bit.
// (RULE_14) Software enables crystal before power-down.
// (RULE_15) Power-on strap forces watchdog enabled.
// (RULE_16) Software-enabled watchdog cannot reset system.
// (RULE_17) Four watchdog clock sources selectable.
// (RULE_18) Clear bit zeroes counter, cancels delay, reads zero.
module wdtwk_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire wdtwk_pkg::wdtwk_sys_in_t sys_in,
  output wdtwk_pkg::wdtwk_sys_out_t sys_out,
  output logic [1:0] clock_select,
  output logic irq
);
  import wdtwk_pkg::*;

  typedef struct packed {
    logic [2:0] tick_sync;
    logic tick_seen;
    logic force_sync1;
    logic force_sync2;
    logic force_sync3;
    logic strap_en;
    wdtwk_aphase_t ap;
    logic [31:0] rdata;
    logic en;
    logic interrupt_enable_bit;
    logic reset_enable_bit;
    logic wakeup_enable_bit;
    logic [2:0] tsel;
    logic [1:0] dsel;
    logic [1:0] csel;
    logic to_flag;
    logic rst_src;
    logic wk_src;
    logic [2:0] stat;
    logic [2:0] mask;
    wdtwk_phase_t phase;
    logic [WDTWK_CNT_W-1:0] cnt;
    logic [10:0] dcnt;
    logic [5:0] hcnt;
    logic cpu_rst;
    logic wakeup;
    logic irq;
  } wdtwk_state_t;

  wdtwk_state_t st_ff;
  wdtwk_state_t nxt_st;

  logic [WDTWK_CNT_W-1:0] limit;
  logic [10:0] dly_len;
  logic tick;
  logic wr;
  logic [31:0] ctl_rd;
  logic [31:0] alt_rd;
  logic timeout;
  logic [2:0] evt;

  logic count_run;
  logic wake_ok;
  logic dly_done;
  logic hold_done;

  logic wr_ctl;
  logic wr_alt;
  logic wr_stat;
  logic wr_mask;

  logic rd_req;
  logic [31:0] rd_word;
  logic strap_level;

  always_comb begin
    // Interval is 2^(4+2*code) clocks; timeout when count reaches interval minus one.
    limit = WDTWK_CNT_W'((64'd1 << (4 + 2 * st_ff.tsel)) - 64'd1); // RULE_02
    case (st_ff.dsel) // RULE_07
      2'd0: dly_len = WDTWK_DLY_0;
      2'd1: dly_len = WDTWK_DLY_1;
      2'd2: dly_len = WDTWK_DLY_2;
      default: dly_len = WDTWK_DLY_3;
    endcase
  end

  // A watchdog edge counts once the second and third stages agree on a new level.
  assign tick = (st_ff.tick_sync[1] == st_ff.tick_sync[2]) && (st_ff.tick_sync[2] != st_ff.tick_seen);
  assign wr = st_ff.ap.sel && st_ff.ap.write;
  // Only the slow crystal keeps running in power-down, so only that source may advance the count there.
  assign count_run = st_ff.en && (!sys_in.powered_down || st_ff.csel == WDTWK_CSEL_LXT); // RULE_12
  assign wake_ok = st_ff.wakeup_enable_bit && st_ff.csel == WDTWK_CSEL_LXT && sys_in.powered_down; // RULE_12
  assign timeout = tick && count_run && st_ff.phase == WDTWK_RUN
                   && st_ff.cnt == limit; // RULE_04

  assign dly_done = st_ff.dcnt == dly_len; // RULE_07
  assign hold_done = st_ff.hcnt == 6'(WDTWK_HOLD_CLKS - 1); // RULE_09

  assign wr_ctl = wr && st_ff.ap.addr == WDTWK_OFS_CTL;
  assign wr_alt = wr && st_ff.ap.addr == WDTWK_OFS_ALTCTL;
  assign wr_stat = wr && st_ff.ap.addr == WDTWK_OFS_STAT;
  assign wr_mask = wr && st_ff.ap.addr == WDTWK_OFS_MASK;

  assign rd_req = hsel && htrans[1] && hready && !hwrite;

  // The strap is a pin level, so it counts only once the second and third stages agree.
  assign strap_level = st_ff.force_sync2 && st_ff.force_sync3;

  always_comb begin
    ctl_rd = 32'h0000_0000;
    ctl_rd[WDTWK_BIT_RESET_ENABLE_BIT] = st_ff.reset_enable_bit;
    ctl_rd[WDTWK_BIT_RSTF] = st_ff.rst_src;
    ctl_rd[WDTWK_BIT_TOF] = st_ff.to_flag;
    ctl_rd[WDTWK_BIT_WAKEUP_ENABLE_BIT] = st_ff.wakeup_enable_bit;
    ctl_rd[WDTWK_BIT_WKF] = st_ff.wk_src;
    ctl_rd[WDTWK_BIT_INTERRUPT_ENABLE_BIT] = st_ff.interrupt_enable_bit;
    ctl_rd[WDTWK_BIT_EN] = st_ff.en;
    ctl_rd[WDTWK_TSEL_LSB +: 3] = st_ff.tsel;
    alt_rd = 32'h0000_0000;
    alt_rd[1:0] = st_ff.dsel;
    alt_rd[WDTWK_CSEL_LSB +: 2] = st_ff.csel;
  end

  // Unmapped offsets read as zero so that software probing the map sees no stale data.
  always_comb begin
    case (haddr[11:0])
      WDTWK_OFS_CTL: rd_word = ctl_rd;
      WDTWK_OFS_ALTCTL: rd_word = alt_rd;
      WDTWK_OFS_STAT: rd_word = {29'h0, st_ff.stat};
      WDTWK_OFS_MASK: rd_word = {29'h0, st_ff.mask};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    evt = 3'b000;
    nxt_st.tick_sync = {st_ff.tick_sync[1:0], sys_in.wdt_tick};
    if (tick) begin
      nxt_st.tick_seen = st_ff.tick_sync[2];
    end
    nxt_st.force_sync1 = sys_in.force_on;
    nxt_st.force_sync2 = st_ff.force_sync1;
    nxt_st.force_sync3 = st_ff.force_sync2;
    nxt_st.wakeup = 1'b0;

    // Bus address phase capture; zero wait states.
    if (hready) begin
      nxt_st.ap.sel = hsel && htrans[1];
      nxt_st.ap.write = hwrite;
      nxt_st.ap.addr = haddr[11:0];
    end
    if (rd_req) begin
      nxt_st.rdata = rd_word;
    end

    // Strap is caught after reset release and forces the watchdog on.
    if (strap_level && !st_ff.en && !st_ff.strap_en) begin
      nxt_st.strap_en = 1'b1; // RULE_15
      nxt_st.en = 1'b1; // RULE_15
      nxt_st.cnt = '0;
    end

    // Counter and phase machine.
    if (tick && count_run) begin
      case (st_ff.phase)
        WDTWK_RUN: begin
          nxt_st.cnt = WDTWK_CNT_W'(st_ff.cnt + 1'b1); // RULE_01
          if (timeout) begin
            nxt_st.phase = WDTWK_DELAY;
            nxt_st.dcnt = 11'd1;
          end
        end
        WDTWK_DELAY: begin
          nxt_st.dcnt = 11'(st_ff.dcnt + 1'b1);
          if (dly_done) begin
            // A watchdog enabled only by software may not reset the system.
            if (st_ff.reset_enable_bit && st_ff.strap_en) begin // RULE_16
              nxt_st.phase = WDTWK_HOLD; // RULE_08
              nxt_st.hcnt = 6'd0;
              evt[WDTWK_EVT_RST] = 1'b1;
            end else begin
              nxt_st.phase = WDTWK_RUN;
              nxt_st.cnt = '0;
            end
          end
        end
        WDTWK_HOLD: begin
          nxt_st.hcnt = 6'(st_ff.hcnt + 1'b1);
          if (hold_done) begin // RULE_09
            nxt_st.phase = WDTWK_RUN;
            nxt_st.cnt = '0;
          end
        end
        default: nxt_st.phase = WDTWK_RUN;
      endcase
    end
    if (evt[WDTWK_EVT_RST]) begin
      nxt_st.cpu_rst = 1'b1; // RULE_08
    end else if (st_ff.phase != WDTWK_HOLD) begin
      nxt_st.cpu_rst = 1'b0;
    end
    if (st_ff.phase == WDTWK_HOLD && nxt_st.phase == WDTWK_RUN) begin
      nxt_st.cpu_rst = 1'b0; // RULE_09
      // The CPU reset returns control to reset values, except EN which follows the strap; the source flag is kept.
      nxt_st.en = st_ff.strap_en;
      nxt_st.interrupt_enable_bit = 1'b0;
      nxt_st.reset_enable_bit = 1'b0;
      nxt_st.wakeup_enable_bit = 1'b0;
      nxt_st.tsel = WDTWK_CTL_RST[WDTWK_TSEL_LSB +: 3];
      nxt_st.to_flag = 1'b0; // RULE_10
    end

    if (sys_in.pd_enter) begin
      nxt_st.cnt = '0; // RULE_11
    end

    // Software writes.
    if (wr_ctl) begin
      if (hwdata[WDTWK_BIT_EN] && !st_ff.en) begin
        nxt_st.cnt = '0; // RULE_03
      end
      nxt_st.en = hwdata[WDTWK_BIT_EN] || st_ff.strap_en; // RULE_03
      nxt_st.interrupt_enable_bit = hwdata[WDTWK_BIT_INTERRUPT_ENABLE_BIT];
      nxt_st.reset_enable_bit = hwdata[WDTWK_BIT_RESET_ENABLE_BIT];
      nxt_st.wakeup_enable_bit = hwdata[WDTWK_BIT_WAKEUP_ENABLE_BIT];
      nxt_st.tsel = hwdata[WDTWK_TSEL_LSB +: 3];
      if (hwdata[WDTWK_BIT_TOF]) nxt_st.to_flag = 1'b0;
      if (hwdata[WDTWK_BIT_RSTF]) nxt_st.rst_src = 1'b0;
      if (hwdata[WDTWK_BIT_WKF]) nxt_st.wk_src = 1'b0;
      if (hwdata[WDTWK_BIT_CLR] && st_ff.phase != WDTWK_HOLD) begin // RULE_18
        nxt_st.cnt = '0; // RULE_18
        nxt_st.phase = WDTWK_RUN; // RULE_18
      end
    end
    if (wr_alt) begin
      nxt_st.dsel = hwdata[1:0];
      nxt_st.csel = hwdata[WDTWK_CSEL_LSB +: 2]; // RULE_17
    end
    if (wr_stat) begin
      nxt_st.stat = st_ff.stat & ~hwdata[2:0];
    end
    if (wr_mask) begin
      nxt_st.mask = hwdata[2:0];
    end

    // Hardware sets win over software clears.
    if (timeout) begin
      nxt_st.to_flag = 1'b1; // RULE_04
      evt[WDTWK_EVT_TO] = 1'b1;
      if (wake_ok) begin // RULE_12
        nxt_st.wakeup = 1'b1;
        nxt_st.wk_src = 1'b1; // RULE_13
        evt[WDTWK_EVT_WK] = 1'b1;
      end
    end
    if (evt[WDTWK_EVT_RST]) begin
      nxt_st.rst_src = 1'b1; // RULE_08
    end
    nxt_st.stat = nxt_st.stat | evt;
    nxt_st.irq = (st_ff.interrupt_enable_bit && nxt_st.to_flag) || |(nxt_st.stat & nxt_st.mask); // RULE_05
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.tsel <= WDTWK_CTL_RST[WDTWK_TSEL_LSB +: 3];
      st_ff.phase <= WDTWK_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign clock_select = st_ff.csel;
  assign irq = st_ff.irq;
  assign sys_out.cpu_rst = st_ff.cpu_rst;
  assign sys_out.irq = st_ff.irq;
  assign sys_out.wakeup = st_ff.wakeup;
  assign sys_out.wk_src = st_ff.wk_src;
  assign sys_out.rst_src = st_ff.rst_src;
endmodule

/* File: tb/wdtwk_chk.sv */
// Purpose: Port assertions for the watchdog timer with wakeup.
// Assumes: One hclk domain; strap changes only under reset.
// Notes: Wakeup properties need the slow crystal selected while powered down.
module wdtwk_chk
  import wdtwk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire wdtwk_pkg::wdtwk_sys_in_t sys_in,
  input wire wdtwk_pkg::wdtwk_sys_out_t sys_out,
  input wire logic [1:0] clock_select,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rst_start;
    $rose(sys_out.cpu_rst);
  endsequence
  sequence rst_hold;
    sys_out.cpu_rst [*8];
  endsequence
  bus_ready_a: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
  irq_mirror_a: assert property (irq == sys_out.irq) else $error("irq outputs differ");
  rst_hold_a: assert property (rst_start |-> rst_hold) else $error("cpu reset too short");
  rst_flag_a: assert property (rst_start |-> ##[0:4] sys_out.rst_src) else $error("no reset flag");
  flag_keep_a: assert property ($fell(sys_out.cpu_rst) |-> sys_out.rst_src) else $error("reset flag lost");
  strap_only_a: assert property (sys_out.cpu_rst |-> sys_in.force_on) else $error("reset without strap");
  wake_clk_a: assert property (sys_out.wakeup |-> clock_select == WDTWK_CSEL_LXT) else $error("bad wake");
  wake_flag_a: assert property (sys_out.wakeup |-> ##[0:2] sys_out.wk_src) else $error("no wake flag");
endmodule

bind wdtwk_top wdtwk_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .sys_in(sys_in), .sys_out(sys_out), .clock_select(clock_select), .irq(irq));

/* File: tb/wdtwk_tb_top.sv */
// Purpose: Self-checking bench for the watchdog over AHB-Lite.
// Assumes: The watchdog tick toggles every 8 hclk, free running.
// Notes: Tick counts allow one edge of slack because the tick is synchronised.
module wdtwk_tb_top;
  import wdtwk_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, clock_select;
  logic [2:0] hsize;
  wdtwk_sys_in_t sys_in;
  wdtwk_sys_out_t sys_out;
  int err_count, cmp_count, tick_cnt, cyc, s0, s1;
  logic rst_seen;
  wdtwk_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sys_in(sys_in), .sys_out(sys_out), .clock_select(clock_select), .irq(irq));
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask
  task automatic wt(input int n);
    s1 = tick_cnt + n;
    wait (tick_cnt >= s1);
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always begin
    repeat (8) @(posedge hclk);
    sys_in.wdt_tick <= ~sys_in.wdt_tick;
    tick_cnt++;
  end
  // The ceiling is several times the longest expected run, so a hang ends the run.
  always @(posedge hclk) begin
    cyc++;
    if (sys_out.cpu_rst === 1'b1) rst_seen = 1'b1;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH at %0t: run timed out", $time);
      stop_test();
    end
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    sys_in = '0;
    rst_seen = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(WDTWK_OFS_CTL, 32'hFFFF_FFFF, WDTWK_CTL_RST);
    rdc(WDTWK_OFS_ALTCTL, 32'hFFFF_FFFF, WDTWK_ALT_RST);
    rdc(12'h010, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, WDTWK_OFS_ALTCTL, 32'h0000_1001 * 32'(i));
      rdc(WDTWK_OFS_ALTCTL, 32'h0000_3003, 32'h0000_1001 * 32'(i));
      @(negedge hclk);
      chk(32'(clock_select), 32'(i));
    end
    $display("Test register map done");
    bus(1'b1, WDTWK_OFS_ALTCTL, 32'h0000_0003);
    bus(1'b1, WDTWK_OFS_CTL, 32'h0000_0082);
    wt(12);
    @(posedge hclk);
    sys_in.pd_enter <= 1'b1;
    @(posedge hclk);
    sys_in.pd_enter <= 1'b0;
    wt(12);
    bus(1'b1, WDTWK_OFS_CTL, 32'h0000_0083);
    rdc(WDTWK_OFS_CTL, 32'h0000_0009, 32'h0000_0000);
    wt(12);
    rdc(WDTWK_OFS_CTL, 32'h0000_0008, 32'h0000_0000);
    wt(6);
    rdc(WDTWK_OFS_CTL, 32'h0000_0008, 32'h0000_0008);
    @(negedge hclk);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, WDTWK_OFS_MASK, 32'h0000_0001);
    repeat (2) @(negedge hclk);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, WDTWK_OFS_STAT, 32'h0000_0007);
    repeat (2) @(negedge hclk);
    chk(32'(irq), 32'h0000_0000);
    wt(20);
    chk(32'(rst_seen), 32'h0000_0000);
    bus(1'b1, WDTWK_OFS_CTL, 32'h0000_0000);
    $display("Test software enable done");
    @(posedge hclk);
    hresetn <= 1'b0;
    sys_in.force_on <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(WDTWK_OFS_CTL, 32'h0000_0080, 32'h0000_0080);
    bus(1'b1, WDTWK_OFS_ALTCTL, 32'h0000_0003);
    bus(1'b1, WDTWK_OFS_CTL, 32'h0000_00C2);
    wait (irq === 1'b1);
    s0 = tick_cnt;
    wait (sys_out.cpu_rst === 1'b1);
    chk(32'((tick_cnt - s0) inside {[2:4]}), 32'h0000_0001);
    s0 = tick_cnt;
    wait (sys_out.cpu_rst === 1'b0);
    chk(32'((tick_cnt - s0) inside {[62:64]}), 32'h0000_0001);
    @(negedge hclk);
    chk(32'(sys_out.rst_src), 32'h0000_0001);
    rdc(WDTWK_OFS_CTL, 32'h0000_0004, 32'h0000_0004);
    $display("Test strap reset done");
    bus(1'b1, WDTWK_OFS_ALTCTL, 32'h0000_3003);
    bus(1'b1, WDTWK_OFS_MASK, 32'h0000_0004);
    bus(1'b1, WDTWK_OFS_CTL, 32'h0000_0091);
    @(posedge hclk);
    sys_in.pd_enter <= 1'b1;
    sys_in.powered_down <= 1'b1;
    @(posedge hclk);
    sys_in.pd_enter <= 1'b0;
    wait (sys_out.wakeup === 1'b1);
    @(negedge hclk);
    chk(32'(sys_out.wk_src), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    @(posedge hclk);
    sys_in.powered_down <= 1'b0;
    rdc(WDTWK_OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    rdc(WDTWK_OFS_CTL, 32'h0000_0020, 32'h0000_0020);
    $display("Test wakeup done");
    stop_test();
  end
endmodule
